// >>> shared/ifs_defines.vh
`ifndef IFS_DEFINES_VH
`define IFS_DEFINES_VH

// Parameter addresses
`define IFS_ADDR_IN1_SEL 16'h0704
`define IFS_ADDR_IN2_SEL 16'h0706

// Selector codes
`define IFS_CODE_FREE 16'h0001
`define IFS_CODE_FAULT_RESET 16'h0002
`define IFS_CODE_ENABLE 16'h0003
`define IFS_CODE_HALT 16'h0004
`define IFS_CODE_POS_START 16'h0005
`define IFS_CODE_CUR_LIMIT 16'h0006
`define IFS_CODE_ZERO_CLAMP 16'h0007
`define IFS_CODE_VEL_LIMIT 16'h0008
`define IFS_CODE_HOME 16'h0015
`define IFS_CODE_FWD_STOP 16'h0016
`define IFS_CODE_REV_STOP 16'h0017
`define IFS_CODE_PARSET_SWAP 16'h0018
`define IFS_CODE_VEL_INT_OFF 16'h001C
`define IFS_CODE_MAC_START 16'h001E
`define IFS_CODE_MAC_ARM 16'h001F
`define IFS_CODE_BRAKE_REL 16'h0028

// Factory settings
`define IFS_RST_IN1_SEL 16'h0015
`define IFS_RST_IN2_SEL 16'h0016

// Width of one selector
`define IFS_SEL_W 16

`endif

// >>> core/ifs_input_function_selector.v
// Functional notes
// - Codes 1,2,3,4 select free use, fault reset, power stage enable, halt.
// - Codes 5,6,7,8 select positioning start, current, zero clamp, velocity limit.
// - Codes 21,22,23 select home, forward stop, reverse stop switch.
// - Code 24 swaps parameter set; code 28 disables velocity integral term.
// - Code 30 starts move after capture; code 31 arms it.
// - Code 40 requests manual holding brake release from the input.
// - Selector writes accepted only with power stage disabled; master disables first.
// - Written selector is stored persistently and applied only after next power-on.
// - Factory initialisation sets input one to home, input two to forward stop.
`include "ifs_defines.vh"

module ifs_input_function_selector (
   input wire mclk,
   input wire rst_n,
   input wire digital_input_one,
   input wire digital_input_two,
   input wire power_stage_active,
   input wire factory_init,
   input wire par_wr,
   input wire par_rd,
   input wire [15:0] par_addr,
   input wire [15:0] par_wdata,
   output reg [15:0] par_rdata,
   output wire par_ack,
   output wire par_err,
   output wire [1:0] input_level,
   output wire [1:0] free_level,
   output wire fault_reset_req,
   output wire power_stage_enable_req,
   output wire halt_req,
   output wire positioning_start_req,
   output wire current_limit_req,
   output wire zero_clamp_req,
   output wire velocity_limit_req,
   output wire home_switch,
   output wire forward_travel_stop,
   output wire reverse_travel_stop,
   output wire parameter_set_swap_req,
   output wire velocity_integral_off_req,
   output wire move_after_capture_start,
   output wire move_after_capture_arm,
   output wire brake_release_req,
   output wire [15:0] input_one_active_sel,
   output wire [15:0] input_two_active_sel
);

   // Persistent store, survives reset like non-volatile memory
   reg [15:0] input_one_function_select = `IFS_RST_IN1_SEL;
   reg [15:0] input_two_function_select = `IFS_RST_IN2_SEL;
   reg [15:0] act1_q;
   reg [15:0] act2_q;
   reg loaded_q;
   reg [2:0] sync1_q;
   reg [2:0] sync2_q;
   reg [1:0] lvl_q;
   wire hit1;
   wire hit2;
   wire code_ok;
   wire wr_ok;
   wire [15:0] dec1;
   wire [15:0] dec2;
   wire [15:0] hit_one;
   wire [15:0] hit_two;
   reg [15:1] req_q;
   reg [1:0] free_q;

   function valid_code;
      input [15:0] c;
      begin
         case (c)
            `IFS_CODE_FREE, `IFS_CODE_FAULT_RESET, `IFS_CODE_ENABLE, `IFS_CODE_HALT,
            `IFS_CODE_POS_START, `IFS_CODE_CUR_LIMIT, `IFS_CODE_ZERO_CLAMP,
            `IFS_CODE_VEL_LIMIT, `IFS_CODE_HOME, `IFS_CODE_FWD_STOP, `IFS_CODE_REV_STOP,
            `IFS_CODE_PARSET_SWAP, `IFS_CODE_VEL_INT_OFF, `IFS_CODE_MAC_START,
            `IFS_CODE_MAC_ARM, `IFS_CODE_BRAKE_REL: valid_code = 1'b1;
            default: valid_code = 1'b0;
         endcase
      end
   endfunction

   assign hit1 = (par_addr == `IFS_ADDR_IN1_SEL);
   assign hit2 = (par_addr == `IFS_ADDR_IN2_SEL);
   assign code_ok = valid_code(par_wdata);
   assign wr_ok = par_wr && (hit1 || hit2) && code_ok && !power_stage_active;
   assign par_ack = (par_wr && wr_ok) || (par_rd && (hit1 || hit2));
   assign par_err = (par_wr && !wr_ok) || (par_rd && !(hit1 || hit2));

   always @(posedge mclk) begin
      if (factory_init) begin
         input_one_function_select <= `IFS_RST_IN1_SEL;
         input_two_function_select <= `IFS_RST_IN2_SEL;
      end else if (wr_ok) begin
         if (hit1) begin
            input_one_function_select <= par_wdata;
         end
         if (hit2) begin
            input_two_function_select <= par_wdata;
         end
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         par_rdata <= 16'h0000;
      end else if (par_rd && hit1) begin
         par_rdata <= input_one_function_select;
      end else if (par_rd && hit2) begin
         par_rdata <= input_two_function_select;
      end else begin
         par_rdata <= 16'h0000;
      end
   end

   // Apply pending value once after power-on
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         act1_q <= `IFS_CODE_FREE;
         act2_q <= `IFS_CODE_FREE;
         loaded_q <= 1'b0;
      end else if (!loaded_q) begin
         act1_q <= input_one_function_select;
         act2_q <= input_two_function_select;
         loaded_q <= 1'b1;
      end
   end

   // Pin synchronisers and agreement filter
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         lvl_q <= 2'h0;
      end else begin
         sync1_q <= {sync1_q[1:0], digital_input_one};
         sync2_q <= {sync2_q[1:0], digital_input_two};
         if (sync1_q[1] == sync1_q[2]) begin
            lvl_q[0] <= sync1_q[2];
         end
         if (sync2_q[1] == sync2_q[2]) begin
            lvl_q[1] <= sync2_q[2];
         end
      end
   end

   assign input_level = lvl_q;
   assign input_one_active_sel = act1_q;
   assign input_two_active_sel = act2_q;

   // One-hot position of the function a selector names
   function [15:0] decode;
      input [15:0] code;
      begin
         decode = 16'h0000;
         case (code)
            `IFS_CODE_FREE: decode[0] = 1'b1;
            `IFS_CODE_FAULT_RESET: decode[1] = 1'b1;
            `IFS_CODE_ENABLE: decode[2] = 1'b1;
            `IFS_CODE_HALT: decode[3] = 1'b1;
            `IFS_CODE_POS_START: decode[4] = 1'b1;
            `IFS_CODE_CUR_LIMIT: decode[5] = 1'b1;
            `IFS_CODE_ZERO_CLAMP: decode[6] = 1'b1;
            `IFS_CODE_VEL_LIMIT: decode[7] = 1'b1;
            `IFS_CODE_HOME: decode[8] = 1'b1;
            `IFS_CODE_FWD_STOP: decode[9] = 1'b1;
            `IFS_CODE_REV_STOP: decode[10] = 1'b1;
            `IFS_CODE_PARSET_SWAP: decode[11] = 1'b1;
            `IFS_CODE_VEL_INT_OFF: decode[12] = 1'b1;
            `IFS_CODE_MAC_START: decode[13] = 1'b1;
            `IFS_CODE_MAC_ARM: decode[14] = 1'b1;
            `IFS_CODE_BRAKE_REL: decode[15] = 1'b1;
            default: decode = 16'h0000;
         endcase
      end
   endfunction

   // Decode both active selectors
   assign dec1 = decode(act1_q);
   assign dec2 = decode(act2_q);
   assign hit_one = {16{loaded_q && lvl_q[0]}} & dec1;
   assign hit_two = {16{loaded_q && lvl_q[1]}} & dec2;

   // Registered requests, inactive during reset
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         req_q <= 15'h0000;
         free_q <= 2'h0;
      end else begin
         req_q <= hit_one[15:1] | hit_two[15:1];
         free_q <= {hit_two[0], hit_one[0]};
      end
   end

   assign free_level = free_q;
   assign fault_reset_req = req_q[1];
   assign power_stage_enable_req = req_q[2];
   assign halt_req = req_q[3];
   assign positioning_start_req = req_q[4];
   assign current_limit_req = req_q[5];
   assign zero_clamp_req = req_q[6];
   assign velocity_limit_req = req_q[7];
   assign home_switch = req_q[8];
   assign forward_travel_stop = req_q[9];
   assign reverse_travel_stop = req_q[10];
   assign parameter_set_swap_req = req_q[11];
   assign velocity_integral_off_req = req_q[12];
   assign move_after_capture_start = req_q[13];
   assign move_after_capture_arm = req_q[14];
   assign brake_release_req = req_q[15];

endmodule

// >>> bench/ifs_switch_model.sv
module ifs_switch_model (
   input wire mclk,
   input wire [1:0] want,
   output logic digital_input_one,
   output logic digital_input_two
);
   timeunit 1ns;
   timeprecision 1ns;
   // Contacts follow the request one cycle late
   always @(posedge mclk) {digital_input_two, digital_input_one} <= #2 want;
endmodule

// >>> bench/ifs_selector_checker.sv
module ifs_selector_checker (
   input wire mclk,
   input wire rst_n,
   input wire power_stage_active,
   input wire par_wr,
   input wire par_ack,
   input wire par_err,
   input wire home_switch,
   input wire brake_release_req,
   input wire [1:0] input_level,
   input wire [15:0] par_wdata,
   input wire [15:0] input_one_active_sel,
   input wire [15:0] input_two_active_sel
);
   timeunit 1ns;
   timeprecision 1ns;
   wire [15:0] a = input_one_active_sel;
   wire [15:0] b = input_two_active_sel;
   wire p = input_level[0];
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   chk_busy_refuse: assert property (
      par_wr && power_stage_active |-> par_err && !par_ack)
      else $error("write taken while powered");
   chk_code_refuse: assert property (par_wr && par_wdata == 16'h9 |-> par_err)
      else $error("unlisted code taken");
   chk_sel_frozen: assert property ($past(rst_n, 2) |-> $stable(a) && $stable(b))
      else $error("active selector moved");
   chk_write_pending: assert property (par_wr && par_ack |=> $stable(a) [*3])
      else $error("write applied at once");
   chk_home_route: assert property (
      a == 16'h15 && b != 16'h15 |=> home_switch == $past(p))
      else $error("home not routed");
   chk_home_quiet: assert property (a != 16'h15 && b != 16'h15 |=> !home_switch)
      else $error("home not quiet");
   chk_brake_route: assert property (
      a == 16'h28 && b != 16'h28 |=> brake_release_req == $past(p))
      else $error("brake not routed");
   chk_brake_quiet: assert property (
      a != 16'h28 && b != 16'h28 |=> !brake_release_req)
      else $error("brake not quiet");
   cover property (par_wr && par_err);
   cover property (par_wr && par_ack);
   cover property ($rose(home_switch));
   cover property ($rose(brake_release_req));
endmodule
bind ifs_input_function_selector ifs_selector_checker u_ifs_selector_checker (.*);

// >>> bench/input_function_selector_bench.sv
module input_function_selector_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'h0, rst_n = 1'h0, power_stage_active = 1'h0, factory_init = 1'h1;
   logic [1:0] e;
   logic par_wr = 1'h0, par_rd = 1'h0, par_ack, par_err;
   logic [15:0] par_addr = 16'h0, par_wdata = 16'h0, par_rdata, r, q[$], sq[$];
   logic [15:0] input_one_active_sel, input_two_active_sel;
   logic [15:0] codes[16] = '{16'h1, 16'h2, 16'h3, 16'h4, 16'h5, 16'h6, 16'h7, 16'h8,
      16'h15, 16'h16, 16'h17, 16'h18, 16'h1C, 16'h1E, 16'h1F, 16'h28};
   logic [1:0] want = 2'h0, input_level, free_level;
   wire digital_input_one, digital_input_two;
   wire [15:0] fn;
   int miscompares = 0, n_checks = 0, seed = 77, cyc = 0;
   event seen;
   assign fn[0] = free_level[0];
   always #20 mclk = ~mclk;
   ifs_switch_model u_ifs_switch_model (.*);
   ifs_input_function_selector u_ifs_input_function_selector (.*, .fault_reset_req(fn[1]),
      .power_stage_enable_req(fn[2]), .halt_req(fn[3]), .positioning_start_req(fn[4]),
      .current_limit_req(fn[5]), .zero_clamp_req(fn[6]), .velocity_limit_req(fn[7]),
      .home_switch(fn[8]), .forward_travel_stop(fn[9]), .reverse_travel_stop(fn[10]),
      .parameter_set_swap_req(fn[11]), .velocity_integral_off_req(fn[12]),
      .move_after_capture_start(fn[13]), .move_after_capture_arm(fn[14]),
      .brake_release_req(fn[15]));
   task automatic chk(input logic [15:0] v, input logic [15:0] x);
      n_checks++;
      if (v !== x) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, v, x);
      end
   endtask
   task automatic note(input logic [15:0] v, input logic [15:0] x);
      sq.push_back(v);
      q.push_back(x);
      -> seen;
   endtask
   always @(seen) while (q.size() > 0) chk(sq.pop_front(), q.pop_front());
   task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
      @(posedge mclk);
      #2 {par_wr, par_rd, par_addr, par_wdata} = {w, !w, a, d};
      #1 e = {par_ack, par_err};
      @(posedge mclk);
      #2 {par_wr, par_rd} = 2'h0;
      r = par_rdata;
   endtask
   task automatic boot();
      rst_n = 1'h0;
      repeat (8) @(posedge mclk);
      #2 rst_n = 1'h1;
      repeat (2) @(posedge mclk);
      #2;
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge mclk) if (++cyc == 3000) begin
      miscompares++;
      give_verdict();
   end
   initial begin
      boot();
      factory_init = 1'h0;
      boot();
      note(input_one_active_sel, 16'h15);
      note(input_two_active_sel, 16'h16);
      power_stage_active = 1'h1;
      acc(1'h1, 16'h0704, 16'h4);
      note({14'h0, e}, 16'h1);
      power_stage_active = 1'h0;
      acc(1'h1, 16'h0704, 16'h9);
      note({14'h0, e}, 16'h1);
      acc(1'h0, 16'h0704, 16'h0);
      note(r, 16'h15);
      for (int i = 0; i < 16; i++) begin
         acc(1'h1, 16'h0704, codes[i]);
         note({14'h0, e}, 16'h2);
         note(input_one_active_sel, i ? codes[i - 1] : 16'h15);
         boot();
         note(input_one_active_sel, codes[i]);
         r = 16'($random(seed));
         want = {1'h0, r[0]};
         #320;
         note(fn, r[0] ? 16'h1 << i : 16'h0);
      end
      want = 2'h2;
      #320;
      note(fn, 16'h0200);
      acc(1'h1, 16'h0706, 16'h1);
      note({14'h0, e}, 16'h2);
      acc(1'h0, 16'h0706, 16'h0);
      note(r, 16'h1);
      note(input_two_active_sel, 16'h16);
      boot();
      want = 2'h3;
      #320;
      note(input_two_active_sel, 16'h1);
      note(fn, 16'h8000);
      note({14'h0, free_level}, 16'h2);
      note({14'h0, input_level}, 16'h3);
      factory_init = 1'h1;
      acc(1'h0, 16'h0706, 16'h0);
      factory_init = 1'h0;
      note(r, 16'h16);
      #1;
      give_verdict();
   end
endmodule
